// >>> logic/spfr_panel.sv
// spfr_panel.sv: front-panel service logic, menu, fault recall and test mode
// assumes synchronous inputs, 100 MHz clock, fault events as one-cycle pulses
//
// Overview of operation
// [R01] horn held at key-on enters menu; prompt scrolls until horn released
// [R02] first item is fault recall; pad press there enters fault recall
// [R03] fault recall first shows error prefix with board revision letter
// [R04] detected faults are shown and stored for the next session
// [R05] after pad release show none if store empty, else stored codes
// [R06] horn shows erase prompt; second horn erases, pad returns to codes
// [R07] only key-off leaves a service mode
// [R08] horn on recall item advances to test item; pad enters test mode
// [R09] red battery indicator follows speed controller reverse signal
// [R10] yellow battery indicator follows forward/reverse signal
// [R11] green indicator follows status, flashes controller fault code on fault
// [R12] without over-current, display shows battery voltage to 0.15 V
// [R13] top segment lit while interlock open, flashing if actuator commanded
// [R14] bottom segment lit while seat switch closed
// [R15] over-current shows E plus two-digit code instead of voltage
// [R16] each horn press and release toggles pad motor output
// [R17] horn led off/green when consistent, flashing red on mismatch
// [R18] each pad press steps actuator off-up, on-down, off-down, on-up
// [R19] actuator inhibited while interlock open; commanded on flashes both leds
// [R20] off states: pad led dark, flashing red/green if current sensed
// [R21] on-down: steady green with current, flashing green without
// [R22] on-up: steady red with current, flashing red without
// [R23] normal operation cycles active error codes once per second
// [R24] switches debounced, one step per press and release
// [R25] error store persists across key cycles until erased
`timescale 1ns/100ps
`default_nettype none
`include "spfr_defines.svh"

module spfr_panel
  import spfr_pkg::*;
#(
  parameter int unsigned DEB_CYCLES   = `SPFR_DEBOUNCE_MS * 1000 * `SPFR_CLK_MHZ,
  parameter int unsigned FLASH_CYCLES = `SPFR_FLASH_MS * 1000 * `SPFR_CLK_MHZ,
  parameter int unsigned CYCLE_CYCLES = `SPFR_CYCLE_MS * 1000 * `SPFR_CLK_MHZ,
  parameter logic [7:0]  REV_LETTER   = `SPFR_REV_LETTER
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // operator switches
  input  wire logic        i_key_on,
  input  wire logic        i_horn_sw,
  input  wire logic        i_pad_sw,
  // speed controller
  input  wire logic        i_sc_rev,
  input  wire logic        i_sc_fwdrev,
  input  wire logic        i_sc_status,
  input  wire logic        i_sc_fault,
  input  wire logic [3:0]  i_sc_fault_code,
  // machine sensing
  input  wire logic        i_interlock_open,
  input  wire logic        i_seat_closed,
  input  wire logic        i_pad_current,
  input  wire logic        i_act_current,
  input  wire logic [11:0] i_batt_volt_bcd,
  input  wire logic        i_oc_fault,
  input  wire logic [7:0]  i_oc_code_bcd,
  input  wire logic        i_fault_valid,
  input  wire logic [7:0]  i_fault_code,
  // display
  output logic [3:0]       o_disp_sel,
  output logic [11:0]      o_disp_val,
  output logic             o_seg_top,
  output logic             o_seg_bot,
  // indicators
  output spfr_led_t        o_led,
  // outputs to the machine
  output logic             o_pad_motor_on,
  output logic             o_act_on,
  output logic             o_act_down
);

  spfr_s_t s_q;
  spfr_s_t s_d;

  // --------------------------------------------------------------------------
  // helper: next set bit after cur in a cyclic mask
  // --------------------------------------------------------------------------
  function automatic logic [`SPFR_DEPTH_W-1:0] next_idx(
    input logic [`SPFR_DEPTH-1:0]   mask,
    input logic [`SPFR_DEPTH_W-1:0] cur
  );
    logic [`SPFR_DEPTH_W-1:0] r;
    logic                     hit;
    logic [`SPFR_DEPTH_W-1:0] j;
    r   = cur;
    hit = 1'b0;
    for (int i = 1; i <= `SPFR_DEPTH; i++) begin
      j = cur + i[`SPFR_DEPTH_W-1:0];
      if (!hit && mask[j]) begin
        r   = j;
        hit = 1'b1;
      end
    end
    return r;
  endfunction : next_idx

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic [1:0] raw;
  logic [1:0] press;
  logic [1:0] rel;
  logic       tick;
  logic       found;
  logic       cmd_on;
  logic [`SPFR_DEPTH-1:0] mask;

  always_comb begin
    s_d   = s_q;
    raw   = {i_pad_sw, i_horn_sw};
    found = 1'b0;

    // switch debounce, one event per press and per release
    for (int k = 0; k < 2; k++) begin
      if (raw[k] == s_q.sw[k]) begin
        s_d.deb_cnt[k] = '0;
      end else if (s_q.deb_cnt[k] >= DEB_CYCLES - 1) begin
        s_d.deb_cnt[k] = '0;
        s_d.sw[k]      = raw[k]; // R24
      end else begin
        s_d.deb_cnt[k] = s_q.deb_cnt[k] + 32'h1;
      end
    end
    press = s_d.sw & ~s_q.sw;
    rel   = ~s_d.sw & s_q.sw; // R24

    // flash phase and controller code pulse count
    if (s_q.blink_cnt >= FLASH_CYCLES - 1) begin
      s_d.blink_cnt = '0;
      s_d.blink     = ~s_q.blink;
      if (s_q.blink) begin
        if (s_q.pulse_cnt >= i_sc_fault_code + `SPFR_CODE_PAUSE) begin
          s_d.pulse_cnt = '0;
        end else begin
          s_d.pulse_cnt = s_q.pulse_cnt + 4'h1;
        end
      end
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h1;
    end

    // once-a-second tick for code cycling
    tick = 1'b0;
    if (s_q.sec_cnt >= CYCLE_CYCLES - 1) begin
      s_d.sec_cnt = '0;
      tick        = 1'b1;
    end else begin
      s_d.sec_cnt = s_q.sec_cnt + 32'h1;
    end

    mask = (s_q.st == ST_RUN) ? s_q.active : s_q.valid;
    if (tick) begin
      s_d.idx = next_idx(mask, s_q.idx); // R23
    end

    // control sequence
    unique case (s_q.st)
      ST_OFF: begin
        s_d.active  = '0;
        s_d.pad_mot = 1'b0;
        s_d.act_st  = 2'h0;
        if (i_key_on) begin
          s_d.st = i_horn_sw ? ST_PROMPT : ST_RUN; // R01
        end
      end
      ST_PROMPT: begin
        if (!i_horn_sw && !s_d.sw[`SPFR_SW_HORN]) begin
          s_d.st = ST_MENU_FR; // R01 R02
        end
      end
      ST_MENU_FR: begin
        if (press[`SPFR_SW_PAD]) begin
          s_d.st = ST_FR_REV; // R02
        end else if (rel[`SPFR_SW_HORN]) begin
          s_d.st = ST_MENU_TEST; // R08
        end
      end
      ST_MENU_TEST: begin
        if (rel[`SPFR_SW_PAD]) begin
          s_d.st = ST_TEST; // R08
        end
      end
      ST_FR_REV: begin
        if (rel[`SPFR_SW_PAD]) begin
          s_d.st  = (s_q.valid == '0) ? ST_FR_NONE : ST_FR_CODES; // R05
          s_d.idx = next_idx(s_q.valid, {`SPFR_DEPTH_W{1'b1}});
        end
      end
      ST_FR_CODES: begin
        if (rel[`SPFR_SW_HORN]) begin
          s_d.st = ST_FR_ERASE; // R06
        end
      end
      ST_FR_ERASE: begin
        if (rel[`SPFR_SW_HORN]) begin
          s_d.st     = ST_FR_NONE; // R06
          s_d.valid  = '0;
          s_d.active = '0;
        end else if (rel[`SPFR_SW_PAD]) begin
          s_d.st = ST_FR_CODES; // R06
        end
      end
      ST_FR_NONE: begin
        s_d.st = ST_FR_NONE;
      end
      ST_TEST: begin
        if (rel[`SPFR_SW_HORN]) begin
          s_d.pad_mot = ~s_q.pad_mot; // R16
        end
        if (rel[`SPFR_SW_PAD]) begin
          s_d.act_st = s_q.act_st + 2'h1; // R18
        end
      end
      ST_RUN: begin
        s_d.st = ST_RUN;
      end
    endcase
    if (!i_key_on) begin
      s_d.st = ST_OFF; // R07
    end

    // fault capture after erase, so a fault in the erase cycle is kept
    if (i_key_on && i_fault_valid) begin
      for (int e = 0; e < `SPFR_DEPTH; e++) begin
        if (!found && s_d.valid[e] && s_d.codes[e] == i_fault_code) begin
          s_d.active[e] = 1'b1; // R04
          found         = 1'b1;
        end
      end
      for (int e = 0; e < `SPFR_DEPTH; e++) begin
        if (!found && !s_d.valid[e]) begin
          s_d.valid[e]  = 1'b1; // R04 R25
          s_d.active[e] = 1'b1;
          s_d.codes[e]  = i_fault_code;
          found         = 1'b1;
        end
      end
    end

    // actuator: states 0 off-up, 1 on-down, 2 off-down, 3 on-up
    cmd_on     = (s_d.st == ST_TEST) && s_d.act_st[0];
    s_d.act_on = cmd_on && !i_interlock_open; // R18 R19
    s_d.act_dn = (s_d.st == ST_TEST) && (s_d.act_st == 2'h1 || s_d.act_st == 2'h2);
    if (s_d.st != ST_TEST) begin
      s_d.pad_mot = 1'b0;
    end

    // display
    s_d.dsp = '0;
    s_d.led = '0;
    unique case (s_d.st)
      ST_OFF: begin
        s_d.dsp.sel = DSP_BLANK;
      end
      ST_PROMPT: begin
        s_d.dsp.sel = DSP_SELECT; // R01
      end
      ST_MENU_FR: begin
        s_d.dsp.sel = DSP_FR_ITEM; // R02
      end
      ST_MENU_TEST: begin
        s_d.dsp.sel = DSP_TEST_ITEM; // R08
      end
      ST_FR_REV: begin
        s_d.dsp.sel = DSP_REV; // R03
        s_d.dsp.val = {4'h0, REV_LETTER};
      end
      ST_FR_CODES: begin
        s_d.dsp.sel = DSP_ERR; // R05
        s_d.dsp.val = {4'h0, s_d.codes[s_d.idx]};
      end
      ST_FR_ERASE: begin
        s_d.dsp.sel = DSP_ERASE; // R06
      end
      ST_FR_NONE: begin
        s_d.dsp.sel = DSP_NONE; // R05 R06
      end
      ST_TEST: begin
        if (i_oc_fault) begin
          s_d.dsp.sel = DSP_OC; // R15
          s_d.dsp.val = {4'h0, i_oc_code_bcd};
        end else begin
          s_d.dsp.sel = DSP_VOLT; // R12
          s_d.dsp.val = i_batt_volt_bcd;
        end
        s_d.dsp.seg_top = i_interlock_open && (!cmd_on || s_q.blink); // R13
        s_d.dsp.seg_bot = i_seat_closed; // R14
        s_d.led.bat_red = i_sc_rev; // R09
        s_d.led.bat_yel = i_sc_fwdrev; // R10
        s_d.led.bat_grn = i_sc_fault ? (s_q.blink && s_q.pulse_cnt < i_sc_fault_code)
                                     : i_sc_status; // R11
        if (s_d.pad_mot != i_pad_current) begin
          s_d.led.horn_red = s_q.blink; // R17
        end else begin
          s_d.led.horn_grn = s_d.pad_mot; // R17
        end
        unique case (s_d.act_st)
          2'h0: s_d.led.pad_red = i_act_current && s_q.blink; // R20
          2'h1: s_d.led.pad_grn = (i_act_current && !i_interlock_open) || s_q.blink; // R21
          2'h2: s_d.led.pad_grn = i_act_current && s_q.blink; // R20
          2'h3: s_d.led.pad_red = (i_act_current && !i_interlock_open) || s_q.blink; // R22
        endcase
        s_d.led.ilk = cmd_on && i_interlock_open && s_q.blink; // R19
      end
      ST_RUN: begin
        if (s_d.active != '0) begin
          s_d.dsp.sel = DSP_ERR; // R04 R23
          s_d.dsp.val = {4'h0, s_d.codes[s_d.active[s_d.idx] ? s_d.idx : next_idx(s_d.active, s_d.idx)]};
        end else begin
          s_d.dsp.sel = DSP_BLANK;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q    <= '0;
      s_q.st <= ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_disp_sel     = s_q.dsp.sel;
  assign o_disp_val     = s_q.dsp.val;
  assign o_seg_top      = s_q.dsp.seg_top;
  assign o_seg_bot      = s_q.dsp.seg_bot;
  assign o_led          = s_q.led;
  assign o_pad_motor_on = s_q.pad_mot;
  assign o_act_on       = s_q.act_on;
  assign o_act_down     = s_q.act_dn;

endmodule : spfr_panel

`default_nettype wire

// >>> logic/spfr_defines.svh
// spfr_defines.svh: constants of the service panel fault recall / test block
// assumes a 100 MHz system clock; times are in milliseconds
`ifndef SPFR_DEFINES_SVH
`define SPFR_DEFINES_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SPFR_CLK_MHZ      100
`define SPFR_DEBOUNCE_MS  20
`define SPFR_FLASH_MS     250
`define SPFR_CYCLE_MS     1000

// ----------------------------------------------------------------------------
// fault store and display
// ----------------------------------------------------------------------------
`define SPFR_DEPTH        8
`define SPFR_DEPTH_W      3
`define SPFR_CODE_PAUSE   4'h2
`define SPFR_REV_LETTER   8'h41

// ----------------------------------------------------------------------------
// switch indices
// ----------------------------------------------------------------------------
`define SPFR_SW_HORN      0
`define SPFR_SW_PAD       1

`endif

// >>> logic/spfr_pkg.sv
// spfr_pkg.sv: types of the service panel fault recall / test block
// assumes spfr_defines.svh is on the include path
`include "spfr_defines.svh"

package spfr_pkg;

  // --------------------------------------------------------------------------
  // control states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_OFF       = 10'h001,
    ST_PROMPT    = 10'h002,
    ST_MENU_FR   = 10'h004,
    ST_MENU_TEST = 10'h008,
    ST_FR_REV    = 10'h010,
    ST_FR_CODES  = 10'h020,
    ST_FR_ERASE  = 10'h040,
    ST_FR_NONE   = 10'h080,
    ST_TEST      = 10'h100,
    ST_RUN       = 10'h200
  } spfr_state_t;

  // --------------------------------------------------------------------------
  // what the status display shows
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    DSP_BLANK     = 4'h0,
    DSP_SELECT    = 4'h1,
    DSP_FR_ITEM   = 4'h2,
    DSP_TEST_ITEM = 4'h3,
    DSP_REV       = 4'h4,
    DSP_NONE      = 4'h5,
    DSP_ERR       = 4'h6,
    DSP_ERASE     = 4'h7,
    DSP_VOLT      = 4'h8,
    DSP_OC        = 4'h9
  } spfr_disp_t;

  typedef struct packed {
    spfr_disp_t  sel;
    logic [11:0] val;
    logic        seg_top;
    logic        seg_bot;
  } spfr_dsp_t;

  typedef struct packed {
    logic bat_red;
    logic bat_yel;
    logic bat_grn;
    logic horn_red;
    logic horn_grn;
    logic pad_red;
    logic pad_grn;
    logic ilk;
  } spfr_led_t;

  // --------------------------------------------------------------------------
  // whole module state
  // --------------------------------------------------------------------------
  typedef struct packed {
    spfr_state_t                   st;
    logic [1:0][31:0]              deb_cnt;
    logic [1:0]                    sw;
    logic [31:0]                   blink_cnt;
    logic                          blink;
    logic [3:0]                    pulse_cnt;
    logic [31:0]                   sec_cnt;
    logic [`SPFR_DEPTH_W-1:0]      idx;
    logic [`SPFR_DEPTH-1:0][7:0]   codes;
    logic [`SPFR_DEPTH-1:0]        valid;
    logic [`SPFR_DEPTH-1:0]        active;
    logic [1:0]                    act_st;
    logic                          pad_mot;
    logic                          act_on;
    logic                          act_dn;
    spfr_dsp_t                     dsp;
    spfr_led_t                     led;
  } spfr_s_t;

endpackage : spfr_pkg

// >>> tb/spfr_panel_monitor.sv
// spfr_panel_monitor.sv: port-level checks of the service panel block
// assumes spfr_pkg is compiled first; bound to every spfr_panel instance
`timescale 1ns/100ps
`default_nettype none

module spfr_panel_monitor
  import spfr_pkg::*;
#(
  parameter logic [7:0] REV_LETTER = 8'h41
) (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  // watched inputs
  input wire logic        i_key_on,
  input wire logic        i_horn_sw,
  input wire logic        i_sc_rev,
  input wire logic        i_seat_closed,
  input wire logic        i_interlock_open,
  input wire logic        i_oc_fault,
  input wire logic [11:0] i_batt_volt_bcd,
  input wire logic        i_pad_current,
  input wire logic        i_act_current,
  // watched outputs
  input wire logic [3:0]  o_disp_sel,
  input wire logic [11:0] o_disp_val,
  input wire logic        o_seg_bot,
  input wire spfr_led_t   o_led,
  input wire logic        o_pad_motor_on,
  input wire logic        o_act_on,
  input wire logic        o_act_down
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  logic tst;
  assign tst = (o_disp_sel == 4'h8) || (o_disp_sel == 4'h9);

  // key turned on while horn is already held
  sequence s_key_horn;
    !i_key_on ##1 (i_key_on && i_horn_sw);
  endsequence

  chk_menu_entry: assert property (s_key_horn |=> ##[0:1] o_disp_sel == 4'h1)
    else $error("menu prompt missing after key-on with horn");
  chk_rev_shown: assert property (o_disp_sel == 4'h4 |-> o_disp_val[7:0] == REV_LETTER)
    else $error("revision letter wrong");
  chk_key_off: assert property (!i_key_on [*2] |=> o_disp_sel == 4'h0 && !o_pad_motor_on && !o_act_on)
    else $error("outputs alive with key off");
  chk_red_follows: assert property ((tst && i_sc_rev) [*3] |-> o_led.bat_red)
    else $error("red battery indicator dark");
  chk_seat_seg: assert property ((tst && $stable(i_seat_closed)) [*3] |-> o_seg_bot == i_seat_closed)
    else $error("bottom segment wrong");
  chk_volt_shown: assert property ((tst && !i_oc_fault && $stable(i_batt_volt_bcd)) [*3]
    |-> o_disp_sel == 4'h8 && o_disp_val == i_batt_volt_bcd)
    else $error("voltage not shown");
  chk_oc_shown: assert property ((tst && i_oc_fault) [*3] |-> o_disp_sel == 4'h9)
    else $error("over-current code not shown");
  chk_act_inhibit: assert property (i_interlock_open [*3] |-> !o_act_on)
    else $error("actuator driven with interlock open");
  chk_horn_green: assert property ((tst && o_pad_motor_on && i_pad_current) [*3]
    |-> o_led.horn_grn && !o_led.horn_red)
    else $error("horn indicator not green");
  chk_motor_mode: assert property (o_pad_motor_on |-> tst)
    else $error("pad motor on outside test mode");
  chk_down_green: assert property ((o_act_on && o_act_down && i_act_current) [*3]
    |-> o_led.pad_grn && !o_led.pad_red)
    else $error("pad indicator not steady green");
endmodule : spfr_panel_monitor

bind spfr_panel spfr_panel_monitor #(.REV_LETTER(REV_LETTER)) u_mon (.i_sys_clk, .i_rst, .i_key_on, .i_horn_sw,
  .i_sc_rev, .i_seat_closed, .i_interlock_open, .i_oc_fault, .i_batt_volt_bcd, .i_pad_current, .i_act_current,
  .o_disp_sel, .o_disp_val, .o_seg_bot, .o_led, .o_pad_motor_on, .o_act_on, .o_act_down);

`default_nettype wire

// >>> tb/spfr_machine.sv
// spfr_machine.sv: pad motor and lift actuator current sensing
// assumes drive outputs of spfr_panel; i_wrong makes pad current disagree
`timescale 1ns/100ps
`default_nettype none

module spfr_machine (
  // clock
  input  wire logic i_sys_clk,
  // drives and fault switch
  input  wire logic i_pad_motor_on,
  input  wire logic i_act_on,
  input  wire logic i_wrong,
  // sensed currents
  output logic      o_pad_current,
  output logic      o_act_current
);
  // currents follow the drive one clock late
  always_ff @(posedge i_sys_clk) begin
    o_pad_current <= i_pad_motor_on ^ i_wrong;
    o_act_current <= i_act_on;
  end
endmodule : spfr_machine

`default_nettype wire

// >>> tb/test_service_panel_fault_recall_test_fsm.sv
// test_service_panel_fault_recall_test_fsm.sv: self-checking bench of spfr_panel
// assumes spfr_pkg, the monitor and spfr_machine are compiled first
`timescale 1ns/100ps
`default_nettype none

module test_service_panel_fault_recall_test_fsm;
  import spfr_pkg::*;
  typedef struct packed { logic [3:0] k; logic [11:0] v; } spfr_note_t;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_key_on = 1'b0, i_horn_sw = 1'b0, i_pad_sw = 1'b0;
  logic i_sc_rev = 1'b0, i_sc_fwdrev = 1'b0, i_sc_status = 1'b0, i_sc_fault = 1'b0, i_fault_valid = 1'b0;
  logic i_interlock_open = 1'b0, i_seat_closed = 1'b0, i_oc_fault = 1'b0, wrong = 1'b0, tog = 1'b0, b1, b2;
  logic [3:0]  i_sc_fault_code = 4'h0, r;
  logic [7:0]  i_oc_code_bcd = 8'h00, i_fault_code = 8'h00, fc;
  logic [11:0] i_batt_volt_bcd = 12'h000;
  logic        i_pad_current, i_act_current, o_seg_top, o_seg_bot, o_pad_motor_on, o_act_on, o_act_down;
  logic [3:0]  o_disp_sel;
  logic [11:0] o_disp_val;
  spfr_led_t   o_led;
  spfr_note_t  q[$], n;
  int          failures = 0, n_compared = 0;
  logic [9:0]  stp [4] = '{10'h302, 10'h100, 10'h204, 10'h000};
  event        seen;

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  spfr_panel #(.DEB_CYCLES(4), .FLASH_CYCLES(4), .CYCLE_CYCLES(16)) u_dut (.i_sys_clk, .i_rst, .i_key_on,
    .i_horn_sw, .i_pad_sw, .i_sc_rev, .i_sc_fwdrev, .i_sc_status, .i_sc_fault, .i_sc_fault_code,
    .i_interlock_open, .i_seat_closed, .i_pad_current, .i_act_current, .i_batt_volt_bcd, .i_oc_fault,
    .i_oc_code_bcd, .i_fault_valid, .i_fault_code, .o_disp_sel, .o_disp_val, .o_seg_top, .o_seg_bot,
    .o_led, .o_pad_motor_on, .o_act_on, .o_act_down);
  spfr_machine u_mach (.i_sys_clk, .i_pad_motor_on(o_pad_motor_on), .i_act_on(o_act_on), .i_wrong(wrong),
    .o_pad_current(i_pad_current), .o_act_current(i_act_current));

  // ----------------------------------------------------------------------------
  // notes, watcher and checks
  // ----------------------------------------------------------------------------
  function automatic logic [11:0] obs(input logic [3:0] k);
    case (k)
      4'h0: obs = {8'h00, o_disp_sel};
      4'h1: obs = o_disp_val;
      4'h2: obs = {10'h000, o_seg_top, o_seg_bot};
      4'h3: obs = {4'h0, o_led};
      4'h4: obs = {9'h000, o_pad_motor_on, o_act_on, o_act_down};
      default: obs = {11'h000, tog};
    endcase
  endfunction : obs

  task automatic check(input logic [11:0] got, input logic [11:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check

  always @(seen) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      check(obs(n.k), n.v);
    end
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge i_sys_clk);
  endtask : cyc
  task automatic ex(input logic [3:0] k, input logic [11:0] v);
    q.push_back({k, v});
  endtask : ex
  task automatic look();
    @(negedge i_sys_clk);
    ->seen;
    @(posedge i_sys_clk);
  endtask : look
  task automatic sw(input logic h, input logic p);
    i_horn_sw <= h;
    i_pad_sw  <= p;
    cyc(10);
  endtask : sw
  task automatic hit(input logic h);
    sw(h, !h);
    sw(1'b0, 1'b0);
  endtask : hit
  task automatic key_off();
    i_key_on <= 1'b0;
    cyc(4);
    ex(0, 12'h000);
    ex(4, 12'h000);
    look();
  endtask : key_off
  task automatic menu();
    i_horn_sw <= 1'b1;
    i_key_on  <= 1'b1;
    cyc(3);
    ex(0, 12'h001);
    look();
    sw(1'b0, 1'b0);
    ex(0, 12'h002);
    look();
  endtask : menu
  // counts toggles of one flashing bit, {seg_top, led}
  task automatic flash(input int b);
    int c;
    logic l;
    logic v;
    c = 0;
    @(negedge i_sys_clk);
    l = (b == 8) ? o_seg_top : o_led[b % 8];
    repeat (64) begin
      @(negedge i_sys_clk);
      v = (b == 8) ? o_seg_top : o_led[b % 8];
      if (v !== l) c++;
      l = v;
    end
    tog = (c >= 2);
    ex(5, 12'h001);
    look();
  endtask : flash

  task automatic final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial begin
    cyc(20000);
    failures++;
    final_report();
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h9720498b));
    cyc(4);
    i_rst <= 1'b0;
    cyc(1);
    ex(0, 12'h000);
    look();
    i_key_on <= 1'b1;
    cyc(2);
    fc             = 8'h10 + 8'($urandom_range(0, 15));
    i_fault_valid <= 1'b1;
    i_fault_code  <= fc;
    cyc(1);
    i_fault_code  <= 8'h21;
    cyc(1);
    i_fault_valid <= 1'b0;
    cyc(2);
    ex(0, 12'h006);
    look();
    b1 = 1'b0;
    b2 = 1'b0;
    repeat (40) begin
      @(negedge i_sys_clk);
      b1 = b1 | (o_disp_val === {4'h0, fc});
      b2 = b2 | (o_disp_val === 12'h021);
    end
    tog = b1 & b2;
    ex(5, 12'h001);
    look();
    key_off();
    menu();
    sw(1'b0, 1'b1);
    ex(0, 12'h004);
    ex(1, {4'h0, 8'h41});
    look();
    sw(1'b0, 1'b0);
    ex(0, 12'h006);
    look();
    hit(1'b1);
    ex(0, 12'h007);
    look();
    hit(1'b0);
    ex(0, 12'h006);
    look();
    hit(1'b1);
    hit(1'b1);
    ex(0, 12'h005);
    look();
    key_off();
    menu();
    hit(1'b0);
    ex(0, 12'h005);
    look();
    key_off();
    menu();
    hit(1'b1);
    ex(0, 12'h003);
    look();
    hit(1'b0);
    ex(0, 12'h008);
    look();
    repeat (4) begin
      r = 4'($urandom);
      {i_sc_rev, i_sc_fwdrev, i_sc_status, i_seat_closed} <= r;
      i_batt_volt_bcd <= 12'($urandom) & 12'h777;
      cyc(4);
      ex(3, {4'h0, r[3:1], 5'h00});
      ex(2, {11'h000, r[0]});
      ex(1, i_batt_volt_bcd);
      look();
    end
    {i_sc_rev, i_sc_fwdrev, i_sc_status} <= 3'h0;
    i_oc_fault    <= 1'b1;
    i_oc_code_bcd <= 8'h42;
    cyc(4);
    ex(0, 12'h009);
    look();
    i_oc_fault <= 1'b0;
    i_horn_sw  <= 1'b1;
    cyc(2);
    i_horn_sw <= 1'b0;
    cyc(10);
    ex(4, 12'h000);
    look();
    hit(1'b1);
    ex(4, 12'h004);
    ex(3, 12'h008);
    look();
    wrong <= 1'b1;
    flash(4);
    wrong <= 1'b0;
    hit(1'b1);
    ex(4, 12'h000);
    look();
    for (int i = 0; i < 4; i++) begin
      hit(1'b0);
      ex(4, {10'h000, stp[i][9:8]});
      ex(3, {4'h0, stp[i][7:0]});
      look();
    end
    hit(1'b0);
    i_interlock_open <= 1'b1;
    cyc(4);
    ex(4, 12'h001);
    look();
    flash(0);
    flash(8);
    i_sc_fault      <= 1'b1;
    i_sc_fault_code <= 4'h3;
    flash(5);
    key_off();
    final_report();
  end
endmodule : test_service_panel_fault_recall_test_fsm

`default_nettype wire
